// ==== lcl_cfg.svh ====
/*
 * Constants for the configurable logic cell: register byte offsets,
 * field positions, field widths and reset values.
 * Assumes it is included by bare name from each design file that needs it.
 */
`ifndef LCL_CFG_SVH
`define LCL_CFG_SVH

// register byte offsets on the wishbone slave
`define LCL_OFF_LUT_A 8'h00
`define LCL_OFF_LUT_B 8'h04
`define LCL_OFF_LUT_C 8'h08
`define LCL_OFF_MODE 8'h0C
`define LCL_OFF_STATUS 8'h10

// widths
`define LCL_LUT4_W 16
`define LCL_LUT3_W 8
`define LCL_MODE_W 13

// mode register field positions
`define LCL_MODE_C2_SRC 0
`define LCL_MODE_C0_SRC 1
`define LCL_MODE_X_SEL 2
`define LCL_MODE_Y_SEL 3
`define LCL_MODE_XQ_SRC_LO 4
`define LCL_MODE_YQ_SRC_LO 6
`define LCL_MODE_XQ_LATCH 8
`define LCL_MODE_YQ_LATCH 9
`define LCL_MODE_XQ_SRVAL 10
`define LCL_MODE_YQ_SRVAL 11
`define LCL_MODE_EC_USE 12

// status register field positions
`define LCL_STAT_X 0
`define LCL_STAT_Y 1
`define LCL_STAT_XQ 2
`define LCL_STAT_YQ 3
`define LCL_STAT_C 4

// reset values
`define LCL_LUT_A_RST 16'h0000
`define LCL_LUT_B_RST 16'h0000
`define LCL_LUT_C_RST 8'h00
`define LCL_MODE_RST 13'h0000

`endif

// ==== lcl_pkg.sv ====
/*
 * Types shared by the configurable logic cell modules.
 * Assumes nothing of its surroundings.
 */
package lcl_pkg;

   // source feeding a storage element
   typedef enum logic [1:0]
   {
      LCL_SRC_A = 2'h0,
      LCL_SRC_B = 2'h1,
      LCL_SRC_C = 2'h2,
      LCL_SRC_DIN = 2'h3
   } lcl_src_t;

   // decoded register target of a bus access
   typedef enum logic [2:0]
   {
      LCL_REG_LUT_A = 3'h0,
      LCL_REG_LUT_B = 3'h1,
      LCL_REG_LUT_C = 3'h2,
      LCL_REG_MODE = 3'h3,
      LCL_REG_STATUS = 3'h4,
      LCL_REG_NONE = 3'h7
   } lcl_reg_t;

endpackage : lcl_pkg

// ==== lcl_lut.sv ====
/*
 * Look-up-table function generator: the input vector indexes a truth
 * table held in configuration storage.
 * Assumes the table is static while the cell operates.
 */
`timescale 1ns/1ps
`default_nettype none

module lcl_lut
#(
   parameter int unsigned NUM_IN = 4
)
(
   // truth table and inputs
   input wire logic [(1 << NUM_IN) - 1:0] table_i,
   input wire logic [NUM_IN - 1:0] sel_i,
   // result
   output logic out_o
);

   // same path for every function: a plain table read
   assign out_o = table_i[sel_i];

endmodule : lcl_lut

`default_nettype wire

// ==== lcl_store.sv ====
/*
 * One storage element of the logic cell: edge-triggered flip-flop, or
 * level-sensitive latch transparent while the enable is high.
 * Assumes one fabric clock and an asynchronous active-high global reset.
 */
`timescale 1ns/1ps
`default_nettype none

module lcl_store
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // data and controls
   input wire logic d_i,
   input wire logic ce_i,
   input wire logic sr_i,
   input wire logic sr_val_i,
   input wire logic latch_i,
   // state
   output logic q_o
);

   logic q_reg;
   logic q_next;

   always_comb
   begin
      q_next = q_reg;
      if (sr_i)
      begin
         q_next = sr_val_i;
      end
      else if (ce_i)
      begin
         q_next = d_i;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         q_reg <= 1'b0;
      end
      else
      begin
         q_reg <= q_next;
      end
   end

   // latch mode passes data through while open; set/reset still dominates
   assign q_o = (latch_i && !sr_i && ce_i) ? d_i : q_reg;

endmodule : lcl_store

`default_nettype wire

// ==== lcl_logic_cell.sv ====
/*
 * Configurable logic cell: two 4-input look-up tables, one 3-input
 * table, output multiplexers and two storage elements, with all
 * configuration held in registers written over classic wishbone.
 * Assumes configuration is loaded before use and held while running,
 * and that CLOCK_I is the single fabric clock for both storage elements.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lcl_cfg.svh"

// Function
// - two 4-input generators, any function
// - generators are configuration-loaded lookup tables
// - third generator, any 3-input function
// - two third-generator inputs independently selectable
// - third generator middle input always external
// - outputs muxed: first/third, second/third
// - two storage elements, usable independently
// - flip-flop, or latch by configuration
// - direct data feeds either storage element
// - middle input loads other element via third
// - two combinational outputs beside registered ones
// - fourteen inputs, four outputs at boundary
// - any five-variable function via third generator
// - static configuration fixes all tables, selections
module lcl_logic_cell
   import lcl_pkg::*;
(
   // clock and reset
   input wire logic CLOCK_I,
   input wire logic RST_I,
   // wishbone slave
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [7:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   // cell inputs from the interconnect
   input wire logic [3:0] LUT_A_INPUTS_I,
   input wire logic [3:0] LUT_B_INPUTS_I,
   input wire logic LUT_C_EXT_LOW_I,
   input wire logic LUT_C_EXT_MID_I,
   input wire logic LUT_C_EXT_TOP_I,
   input wire logic DIRECT_DATA_I,
   input wire logic SET_RESET_I,
   input wire logic CLOCK_ENABLE_I,
   // cell outputs to the interconnect
   output logic X_O,
   output logic Y_O,
   output logic XQ_O,
   output logic YQ_O
);

   // configuration and bus state
   logic [`LCL_LUT4_W - 1:0] lut_a_reg;
   logic [`LCL_LUT4_W - 1:0] lut_a_next;
   logic [`LCL_LUT4_W - 1:0] lut_b_reg;
   logic [`LCL_LUT4_W - 1:0] lut_b_next;
   logic [`LCL_LUT3_W - 1:0] lut_c_reg;
   logic [`LCL_LUT3_W - 1:0] lut_c_next;
   logic [`LCL_MODE_W - 1:0] mode_reg;
   logic [`LCL_MODE_W - 1:0] mode_next;
   logic ack_reg;
   logic ack_next;
   logic [31:0] dat_reg;
   logic [31:0] dat_next;

   // datapath
   logic a_out;
   logic b_out;
   logic c_out;
   logic c_in0;
   logic c_in2;
   logic [2:0] c_sel;
   logic st_ce;
   logic [1:0] st_d;
   logic [1:0] st_q;
   logic [1:0] st_latch;
   logic [1:0] st_srval;
   lcl_src_t st_src [2];
   lcl_reg_t req_reg;
   logic req_new;
   logic [31:0] status_word;

   // address decode, shared by the write and the read path
   function automatic lcl_reg_t decode_reg(input logic [7:0] adr);
      lcl_reg_t r;
      r = LCL_REG_NONE;
      case (adr)
         `LCL_OFF_LUT_A: r = LCL_REG_LUT_A;
         `LCL_OFF_LUT_B: r = LCL_REG_LUT_B;
         `LCL_OFF_LUT_C: r = LCL_REG_LUT_C;
         `LCL_OFF_MODE: r = LCL_REG_MODE;
         `LCL_OFF_STATUS: r = LCL_REG_STATUS;
         default: r = LCL_REG_NONE;
      endcase
      return r;
   endfunction : decode_reg

   // byte-lane merge of a write into an existing word
   function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wr,
                                               input logic [3:0] sel);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            m[i * 8 +: 8] = wr[i * 8 +: 8];
         end
      end
      return m;
   endfunction : merge_bytes

   // storage element data choice, used for both elements
   function automatic logic pick_data(input lcl_src_t src, input logic a, input logic b,
                                      input logic c, input logic din);
      logic d;
      d = 1'b0;
      case (src)
         LCL_SRC_A: d = a;
         LCL_SRC_B: d = b;
         LCL_SRC_C: d = c;
         LCL_SRC_DIN: d = din;
         default: d = 1'b0;
      endcase
      return d;
   endfunction : pick_data

   assign req_reg = decode_reg(ADR_I);
   // one access per request: the ack cycle itself is not a new request
   assign req_new = CYC_I && STB_I && !ack_reg;

   // live view of the cell for software
   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[`LCL_STAT_X] = X_O;
      status_word[`LCL_STAT_Y] = Y_O;
      status_word[`LCL_STAT_XQ] = XQ_O;
      status_word[`LCL_STAT_YQ] = YQ_O;
      status_word[`LCL_STAT_C] = c_out;
   end

   // register file next state
   always_comb
   begin
      lut_a_next = lut_a_reg;
      lut_b_next = lut_b_reg;
      lut_c_next = lut_c_reg;
      mode_next = mode_reg;
      dat_next = dat_reg;
      ack_next = req_new;
      if (req_new)
      begin
         dat_next = 32'h0000_0000;
         if (WE_I)
         begin
            // lanes above a register's width are cut on purpose, so they read back 0
            case (req_reg)
               LCL_REG_LUT_A:
               begin
                  lut_a_next = `LCL_LUT4_W'(merge_bytes({16'h0000, lut_a_reg}, DAT_I,
                                                         SEL_I));
               end
               LCL_REG_LUT_B:
               begin
                  lut_b_next = `LCL_LUT4_W'(merge_bytes({16'h0000, lut_b_reg}, DAT_I,
                                                         SEL_I));
               end
               LCL_REG_LUT_C:
               begin
                  lut_c_next = `LCL_LUT3_W'(merge_bytes({24'h00_0000, lut_c_reg}, DAT_I,
                                                         SEL_I));
               end
               LCL_REG_MODE:
               begin
                  mode_next = `LCL_MODE_W'(merge_bytes({19'h0_0000, mode_reg}, DAT_I,
                                                       SEL_I));
               end
               // status is read-only: a write there changes nothing
               default:
               begin
                  mode_next = mode_reg;
               end
            endcase
         end
         else
         begin
            case (req_reg)
               LCL_REG_LUT_A: dat_next = {16'h0000, lut_a_reg};
               LCL_REG_LUT_B: dat_next = {16'h0000, lut_b_reg};
               LCL_REG_LUT_C: dat_next = {24'h00_0000, lut_c_reg};
               LCL_REG_MODE: dat_next = {19'h0_0000, mode_reg};
               LCL_REG_STATUS: dat_next = status_word;
               default: dat_next = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge CLOCK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         lut_a_reg <= `LCL_LUT_A_RST;
         lut_b_reg <= `LCL_LUT_B_RST;
         lut_c_reg <= `LCL_LUT_C_RST;
         mode_reg <= `LCL_MODE_RST;
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end
      else
      begin
         lut_a_reg <= lut_a_next;
         lut_b_reg <= lut_b_next;
         lut_c_reg <= lut_c_next;
         mode_reg <= mode_next;
         ack_reg <= ack_next;
         dat_reg <= dat_next;
      end
   end

   // one wait state: ack answers the taken request a cycle later,
   // and the write has landed at the edge that raises it
   assign ACK_O = ack_reg;
   assign DAT_O = dat_reg;

   // primary generators, any function of four inputs each
   lcl_lut #(.NUM_IN(4)) u_lut_a
   (
      .table_i(lut_a_reg),
      .sel_i(LUT_A_INPUTS_I),
      .out_o(a_out)
   );

   lcl_lut #(.NUM_IN(4)) u_lut_b
   (
      .table_i(lut_b_reg),
      .sel_i(LUT_B_INPUTS_I),
      .out_o(b_out)
   );

   // third generator inputs: two selectable, middle fixed external
   assign c_in2 = mode_reg[`LCL_MODE_C2_SRC] ? LUT_C_EXT_TOP_I : a_out;
   assign c_in0 = mode_reg[`LCL_MODE_C0_SRC] ? LUT_C_EXT_LOW_I : b_out;
   // with both internal inputs chosen, the middle input picks between
   // the two primary results: any function of five variables
   assign c_sel = {c_in2, LUT_C_EXT_MID_I, c_in0};

   lcl_lut #(.NUM_IN(3)) u_lut_c
   (
      .table_i(lut_c_reg),
      .sel_i(c_sel),
      .out_o(c_out)
   );

   // combinational outputs, independent of the storage elements
   assign X_O = mode_reg[`LCL_MODE_X_SEL] ? c_out : a_out;
   assign Y_O = mode_reg[`LCL_MODE_Y_SEL] ? c_out : b_out;

   // storage element configuration
   assign st_src[0] = lcl_src_t'(mode_reg[`LCL_MODE_XQ_SRC_LO +: 2]);
   assign st_src[1] = lcl_src_t'(mode_reg[`LCL_MODE_YQ_SRC_LO +: 2]);
   assign st_latch = {mode_reg[`LCL_MODE_YQ_LATCH], mode_reg[`LCL_MODE_XQ_LATCH]};
   assign st_srval = {mode_reg[`LCL_MODE_YQ_SRVAL], mode_reg[`LCL_MODE_XQ_SRVAL]};
   // enable is ignored unless configured in, so unused routing cannot stall
   assign st_ce = !mode_reg[`LCL_MODE_EC_USE] || CLOCK_ENABLE_I;

   // two elements on the one fabric clock; direct data can reach either,
   // and the middle input reaches the other through the third generator
   generate
      for (genvar i = 0; i < 2; i++)
      begin : g_store
         assign st_d[i] = pick_data(st_src[i], a_out, b_out, c_out, DIRECT_DATA_I);

         lcl_store u_store
         (
            .clk_i(CLOCK_I),
            .rst_i(RST_I),
            .d_i(st_d[i]),
            .ce_i(st_ce),
            .sr_i(SET_RESET_I),
            .sr_val_i(st_srval[i]),
            .latch_i(st_latch[i]),
            .q_o(st_q[i])
         );
      end
   endgenerate

   // registered outputs give the route for a third separate result
   assign XQ_O = st_q[0];
   assign YQ_O = st_q[1];

endmodule : lcl_logic_cell

`default_nettype wire

// ==== lcl_fabric_model.sv ====
/* interconnect model: drives the cell's fabric inputs from a bench vector.
   assumes the bench changes the vector just after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module lcl_fabric_model
(
   // clock and bench vector
   input wire logic clk_i,
   input wire logic [13:0] vec_i,
   // cell inputs
   output logic [3:0] a_o,
   output logic [3:0] b_o,
   output logic low_o,
   output logic mid_o,
   output logic top_o,
   output logic din_o,
   output logic sr_o,
   output logic ce_o
);
   logic [13:0] pin_reg;

   // routing launches from the one shared fabric clock
   always_ff @(posedge clk_i)
      pin_reg <= vec_i;

   assign {ce_o, sr_o, din_o, top_o, mid_o, low_o, b_o, a_o} = pin_reg;
endmodule : lcl_fabric_model
`default_nettype wire

// ==== lcl_logic_cell_chk.sv ====
/* assertions on the logic cell's bus and datapath pins.
   assumes a bind by name to lcl_logic_cell. */
`timescale 1ns/1ps
`default_nettype none
module lcl_logic_cell_chk
(
   // clock, reset and bus
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [7:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   input wire logic [31:0] DAT_O,
   input wire logic ACK_O,
   // cell pins
   input wire logic [3:0] LUT_A_INPUTS_I,
   input wire logic SET_RESET_I,
   input wire logic CLOCK_ENABLE_I,
   input wire logic X_O,
   input wire logic XQ_O
);
   logic wr;
   logic [15:0] lut_reg;
   logic [15:0] lut_next;
   logic [12:0] mode_reg;
   logic [12:0] mode_next;

   assign wr = CYC_I && STB_I && !ACK_O && WE_I;

   // shadow of table A and mode so datapath checks know the configuration
   always_comb
   begin
      lut_next = lut_reg;
      mode_next = mode_reg;
      if (wr && ADR_I == 8'h00 && SEL_I[0])
         lut_next[7:0] = DAT_I[7:0];
      if (wr && ADR_I == 8'h00 && SEL_I[1])
         lut_next[15:8] = DAT_I[15:8];
      if (wr && ADR_I == 8'h0C && SEL_I[0])
         mode_next[7:0] = DAT_I[7:0];
      if (wr && ADR_I == 8'h0C && SEL_I[1])
         mode_next[12:8] = DAT_I[12:8];
   end

   always_ff @(posedge CLOCK_I or posedge RST_I)
      if (RST_I)
      begin
         lut_reg <= 16'h0000;
         mode_reg <= 13'h0000;
      end
      else
      begin
         lut_reg <= lut_next;
         mode_reg <= mode_next;
      end

   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (RST_I);

   chk_ack_pulse: assert property (ACK_O |=> !ACK_O)
      else $error("ack longer than one cycle");
   chk_ack_answer: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
      else $error("request not answered next cycle");
   chk_ack_cause: assert property ($rose(ACK_O) |-> $past(CYC_I && STB_I))
      else $error("ack without request");
   chk_unmapped_zero: assert property (ACK_O && !WE_I && !(ADR_I inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10})
      |-> DAT_O == 32'h0)
      else $error("unmapped read not zero");
   chk_write_zero: assert property (ACK_O && WE_I |-> DAT_O == 32'h0)
      else $error("read data not cleared by write");
   chk_x_lut_a: assert property (!mode_reg[2] |-> X_O == lut_reg[LUT_A_INPUTS_I])
      else $error("x output differs from table a");
   chk_xq_flop: assert property (!mode_reg[8] && mode_reg[5:4] == 2'h0 && !mode_reg[2] && !mode_reg[12]
      && !SET_RESET_I |=> XQ_O == $past(X_O))
      else $error("xq did not capture generator a");
   chk_sr_value: assert property (SET_RESET_I && !mode_reg[8] |=> XQ_O == $past(mode_reg[10]))
      else $error("xq set-reset value wrong");
   chk_ce_hold: assert property (mode_reg[12] && !CLOCK_ENABLE_I && !SET_RESET_I && !mode_reg[8]
      |=> $stable(XQ_O))
      else $error("xq changed while disabled");
endmodule : lcl_logic_cell_chk

bind lcl_logic_cell lcl_logic_cell_chk u_chk (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .CYC_I(CYC_I), .STB_I(STB_I),
   .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
   .LUT_A_INPUTS_I(LUT_A_INPUTS_I), .SET_RESET_I(SET_RESET_I), .CLOCK_ENABLE_I(CLOCK_ENABLE_I), .X_O(X_O),
   .XQ_O(XQ_O));
`default_nettype wire

// ==== tb_configurable_logic_cell.sv ====
/* self-checking bench for the logic cell over classic wishbone.
   assumes the fabric model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module tb_configurable_logic_cell;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0;
   logic [31:0] q;
   logic [13:0] vec = 14'h0;
   logic [3:0] sel = 4'hF;
   logic [15:0] ta = 16'h6996;
   logic [15:0] tb = 16'hA5C3;
   wire logic [31:0] dat_o;
   wire logic ack, x, y, xq, yq, low, mid, top, din, sr, ce;
   wire logic [3:0] a_in;
   wire logic [3:0] b_in;
   int err_total = 0;
   int checked = 0;

   lcl_fabric_model u_fab (.clk_i(clk), .vec_i(vec), .a_o(a_in), .b_o(b_in), .low_o(low), .mid_o(mid),
      .top_o(top), .din_o(din), .sr_o(sr), .ce_o(ce));
   lcl_logic_cell DUT (.CLOCK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
      .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack), .LUT_A_INPUTS_I(a_in), .LUT_B_INPUTS_I(b_in),
      .LUT_C_EXT_LOW_I(low), .LUT_C_EXT_MID_I(mid), .LUT_C_EXT_TOP_I(top), .DIRECT_DATA_I(din),
      .SET_RESET_I(sr), .CLOCK_ENABLE_I(ce), .X_O(x), .Y_O(y), .XQ_O(xq), .YQ_O(yq));

   initial
      forever #10 clk = ~clk;

   task automatic final_report;
      if (err_total == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   // one classic cycle; request held until ack is seen at an edge
   task automatic wb_io(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
      n = 0;
      // ack is read at the edge itself, before that edge's updates land
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1)
      begin
         err_total++;
         final_report();
      end
      q = dat_o;
      {cyc, stb} <= 2'b00;
   endtask : wb_io

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      wb_io(1'b0, a, 32'h0);
      cmp(q, exp);
   endtask : rdc

   task automatic setin(input logic [13:0] v);
      @(posedge clk);
      vec <= v;
      @(posedge clk);
      #1;
   endtask : setin

   initial
   begin
      logic h;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++)
         rdc(8'(i * 4), 32'h0);
      wb_io(1'b1, 8'h14, 32'hFFFFFFFF);
      rdc(8'h14, 32'h0);
      sel <= 4'h2;
      wb_io(1'b1, 8'h00, 32'hFFFF6996);
      sel <= 4'hF;
      rdc(8'h00, 32'h00006900);
      wb_io(1'b1, 8'h00, 32'hFFFF6996);
      wb_io(1'b1, 8'h04, 32'h0000A5C3);
      wb_io(1'b1, 8'h08, 32'h000000E2);
      rdc(8'h00, 32'h00006996);
      for (int m = 0; m < 2; m++)
      begin
         wb_io(1'b1, 8'h0C, m ? 32'hC : 32'h0);
         for (int k = 0; k < 32; k++)
         begin
            setin({4'h0, k[4], 1'b0, k[3:0], k[3:0]});
            h = k[4] ? ta[k[3:0]] : tb[k[3:0]];
            cmp(x, m ? h : ta[k[3:0]]);
            cmp(y, m ? h : tb[k[3:0]]);
         end
      end
      wb_io(1'b1, 8'h08, 32'h96);
      wb_io(1'b1, 8'h0C, 32'h7);
      for (int j = 0; j < 8; j++)
      begin
         setin({3'h0, j[2:0], 8'h00});
         cmp(x, ^j[2:0]);
      end
      wb_io(1'b1, 8'h08, 32'hCC);
      wb_io(1'b1, 8'h0C, 32'hB3);
      for (int j = 0; j < 4; j++)
      begin
         setin({2'h0, j[0], 1'b0, j[1], 9'h0});
         @(posedge clk);
         #1;
         cmp({x, xq, yq}, {1'b0, j[0], j[1]});
      end
      rdc(8'h10, 32'h0000001E);
      wb_io(1'b1, 8'h0C, 32'h14B3);
      setin(14'h3000);
      @(posedge clk);
      #1;
      cmp({xq, yq}, 2'b10);
      setin(14'h0000);
      @(posedge clk);
      #1;
      cmp(xq, 1'b1);
      setin(14'h2000);
      @(posedge clk);
      #1;
      cmp(xq, 1'b0);
      wb_io(1'b1, 8'h0C, 32'h1130);
      setin(14'h2800);
      cmp(xq, 1'b1);
      setin(14'h2000);
      cmp(xq, 1'b0);
      final_report();
   end
endmodule : tb_configurable_logic_cell
`default_nettype wire
